// ---- rtl/led_gradation_data_receiver.sv ----
// single-wire gradation frame receiver with channel store and pwm
// What this block does
// (R1) Host sends all twenty-four channel values in full-width mode.
// (R2) Full-width mode keeps channels one to 24, ignores later slots.
// (R3) Short full-width frame updates received channels, others keep values.
// (R4) Six or twelve channel mode discards values beyond its channel count.
// (R5) Short six or twelve channel frame leaves unsent channels unchanged.
// (R6) Same-address frames spaced 127 pwm clocks; closer ones dropped.
// (R7) Frames to other identities need no spacing; own frame still taken.
// (R8) Bit rate 0.5 to 2.0 MHz is learned and accepted.
// (R9) Bit period learned from start command, used from address onward.
// (R10) Data edge accepted only inside jitter window around expected time.
// (R11) Identity comes from three identity pins, captured after reset.
// (R12) New data reaches outputs when pwm counter wraps to zero.
// (R13) Reset clears channel and configuration state before any frame.
// (R14) Line pulses shorter than two clocks are filtered out.
// (R15) Seven-bit channel values drive a free-running 7-bit pwm.
// (R16) Incoming line is re-driven on the buffered output for cascade.
`timescale 1ns/100ps
`default_nettype none
module led_gradation_data_receiver
	import led_rx_pkg::*;
#(
	parameter int REF_DIV = PWM_DIV  // clocks per pwm count
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          data_in,
	input  wire ident_pins_t   ident_pins,
	output logic               data_out,
	output logic [NUM_CH-1:0]  led_on,
	output logic               frame_ok
);
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_LEARN = 2'b01,
		ST_BITS  = 2'b11
	} rx_state_t;

	rx_state_t                      state_ff;
	logic                           line_ff;
	logic [1:0]                     flt_cnt_ff;
	logic                           out_ff;
	logic [ADDR_W-1:0]              ident_ff;
	logic                           id_done_ff;
	logic [CNT_W-1:0]               cnt_ff;
	logic [CNT_W-1:0]               per_ff;
	logic [HDR_BITS-1:0]            hdr_ff;
	logic [3:0]                     hdr_cnt_ff;
	logic [VAL_W-1:0]               val_ff;
	logic [2:0]                     vbit_ff;
	logic [4:0]                     ch_ff;
	logic                           wrote_ff;
	logic                           commit_ff;
	logic [6:0]                     guard_ff;
	logic                           ok_ff;
	logic [NUM_CH-1:0][VAL_W-1:0]   shadow_ff;
	logic [NUM_CH-1:0][VAL_W-1:0]   active_ff;
	logic                           edge_take;
	logic                           in_win;
	logic                           early;
	logic                           bit_acc;
	logic                           timeout;
	logic                           frame_end;
	logic                           pwm_tick;
	logic                           pwm_wrap;
	logic                           match;
	chan_wr_t                       wr;

	// (R16) cascade re-drive
	always_ff @(posedge clk) begin
		if (!rst_n)
			out_ff <= 1'b1;
		else if (ce)
			out_ff <= data_in;
	end
	assign data_out = out_ff;

	// (R14) short pulse filter
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_ff    <= 1'b1;
			flt_cnt_ff <= 2'h0;
		end else if (ce) begin
			if (data_in == line_ff)
				flt_cnt_ff <= 2'h0;
			else if (flt_cnt_ff == FILT_LAST) begin
				line_ff    <= data_in;
				flt_cnt_ff <= 2'h0;
			end else
				flt_cnt_ff <= flt_cnt_ff + 2'h1;
		end
	end
	assign edge_take = ce && (data_in != line_ff) && (flt_cnt_ff == FILT_LAST);

	// (R11) identity capture once after reset release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ident_ff   <= 6'h00;
			id_done_ff <= 1'b0;
		end else if (ce && !id_done_ff) begin
			ident_ff   <= ident_pins;
			id_done_ff <= 1'b1;
		end
	end

	// (R10) expected-edge window from the learned period
	assign in_win    = (cnt_ff >= per_ff - TOL_C) && (cnt_ff <= per_ff + TOL_C);
	assign early     = cnt_ff < per_ff - TOL_C;
	assign bit_acc   = (state_ff == ST_BITS) && edge_take && in_win;
	assign timeout   = (state_ff == ST_BITS) && !edge_take
		&& (cnt_ff > per_ff + TOL_C);
	assign frame_end = ce && timeout;
	assign match     = (hdr_ff[HDR_BITS-1:MODE_W] == ident_ff);

	// (R9) receive state and bit timer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= CNT_ONE;
			per_ff   <= PER_MAX_C;
		end else if (ce) begin
			if (cnt_ff != CNT_SAT)
				cnt_ff <= cnt_ff + CNT_ONE;
			case (state_ff)
				ST_IDLE: begin
					if (id_done_ff && edge_take && !data_in) begin
						state_ff <= ST_LEARN;
						cnt_ff   <= CNT_ONE;
					end
				end
				ST_LEARN: begin
					// (R8) learned period must fit the rate range
					if (edge_take && cnt_ff >= PER_MIN_C
							&& cnt_ff <= PER_MAX_C) begin
						per_ff   <= cnt_ff;
						cnt_ff   <= CNT_ONE;
						state_ff <= ST_BITS;
					end else if (edge_take || cnt_ff > PER_MAX_C)
						state_ff <= ST_IDLE;
				end
				ST_BITS: begin
					if (bit_acc)
						cnt_ff <= CNT_ONE;
					else if (timeout || (edge_take && !early))
						state_ff <= ST_IDLE;
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// header and value assembly
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hdr_ff     <= 8'h00;
			hdr_cnt_ff <= 4'h0;
			val_ff     <= 7'h00;
			vbit_ff    <= 3'h0;
			ch_ff      <= 5'h00;
		end else if (ce) begin
			if (state_ff != ST_BITS) begin
				hdr_cnt_ff <= 4'h0;
				vbit_ff    <= 3'h0;
				ch_ff      <= 5'h00;
			end else if (bit_acc) begin
				if (hdr_cnt_ff != HDR_LAST) begin
					hdr_ff     <= {hdr_ff[HDR_BITS-2:0], data_in};
					hdr_cnt_ff <= hdr_cnt_ff + 4'h1;
				end else if (vbit_ff == VBIT_LAST) begin
					vbit_ff <= 3'h0;
					if (ch_ff != CH_FULL)
						ch_ff <= ch_ff + 5'h01;
				end else begin
					val_ff  <= {val_ff[VAL_W-2:0], data_in};
					vbit_ff <= vbit_ff + 3'h1;
				end
			end
		end
	end

	// (R2) (R4) slot limit by mode; (R6) (R7) spacing guard for own id
	always_comb begin
		wr.en  = bit_acc && (hdr_cnt_ff == HDR_LAST)
			&& (vbit_ff == VBIT_LAST) && match && (guard_ff == 7'h00)
			&& (ch_ff < mode_limit(mode_t'(hdr_ff[MODE_W-1:0])));
		wr.idx = ch_ff;
		wr.val = {val_ff[VAL_W-2:0], data_in};
	end

	// (R3) (R5) shadow store, only the written slot changes
	always_ff @(posedge clk) begin
		if (!rst_n)
			shadow_ff <= '0;
		else if (wr.en)
			shadow_ff[wr.idx] <= wr.val;
	end

	// frame bookkeeping: write seen, commit request, spacing guard
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrote_ff  <= 1'b0;
			commit_ff <= 1'b0;
			guard_ff  <= 7'h00;
			ok_ff     <= 1'b0;
		end else if (ce) begin
			ok_ff <= frame_end && wrote_ff && line_ff;
			if (frame_end || state_ff != ST_BITS)
				wrote_ff <= 1'b0;
			else if (wr.en)
				wrote_ff <= 1'b1;
			// set wins over the clear on the same wrap
			if (frame_end && wrote_ff && line_ff)
				commit_ff <= 1'b1;
			else if (pwm_wrap)
				commit_ff <= 1'b0;
			// (R6) hold off the next frame to this id
			if (frame_end && wrote_ff && line_ff)
				guard_ff <= GAP_C;
			else if (pwm_tick && guard_ff != 7'h00)
				guard_ff <= guard_ff - 7'h01;
		end
	end
	assign frame_ok = ok_ff;

	// (R12) (R13) active bank loads on pwm wrap
	always_ff @(posedge clk) begin
		if (!rst_n)
			active_ff <= '0;
		else if (pwm_wrap && commit_ff)
			active_ff <= shadow_ff;
	end

	// (R15) pwm outputs
	pwm_engine #(
		.N_CH (NUM_CH),
		.DIV  (REF_DIV)
	) u_pwm (
		.clk     (clk),
		.rst_n   (rst_n),
		.ce      (ce),
		.duty    (active_ff),
		.pwm_out (led_on),
		.tick    (pwm_tick),
		.wrap    (pwm_wrap)
	);

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_chan_limit: assert property ( // (R2) (R4)
		wr.en |-> wr.idx < mode_limit(mode_t'(hdr_ff[MODE_W-1:0])))
		else $error("channel write beyond mode limit");
	a_keep_unsent: assert property ( // (R3) (R5)
		!wr.en |=> $stable(shadow_ff))
		else $error("shadow changed without a write");
	a_wrap_commit: assert property ( // (R12)
		!(pwm_wrap && commit_ff) |=> $stable(active_ff))
		else $error("outputs changed away from pwm wrap");
	a_bit_window: assert property ( // (R10)
		bit_acc |-> cnt_ff >= per_ff - TOL_C && cnt_ff <= per_ff + TOL_C)
		else $error("bit taken outside window");
	a_rate_range: assert property ( // (R8) (R9)
		state_ff == ST_BITS |-> per_ff >= PER_MIN_C && per_ff <= PER_MAX_C)
		else $error("learned period out of range");
	a_ident_hold: assert property ( // (R11)
		id_done_ff |=> $stable(ident_ff) && id_done_ff)
		else $error("identity changed after capture");
	a_glitch_drop: assert property ( // (R14)
		$changed(line_ff) |-> $past(flt_cnt_ff) == FILT_LAST
			&& $past(data_in, 2) == line_ff)
		else $error("short pulse reached the receiver");
	a_cascade_out: assert property ( // (R16)
		ce |=> data_out == $past(data_in))
		else $error("buffered output mismatch");
	a_gap_guard: assert property ( // (R6) (R7)
		ok_ff |-> guard_ff == GAP_C ##1 !wr.en [*2])
		else $error("spacing guard not armed");
	a_reset_clear: assert property (disable iff (1'b0) // (R13)
		!rst_n |=> active_ff == '0 && shadow_ff == '0 && !id_done_ff)
		else $error("reset left stale channel data");

	c_frame_ok:   cover property (ok_ff);
	c_six_write:  cover property (wr.en && hdr_ff[MODE_W-1:0] == MODE_SIX);
	c_commit:     cover property (pwm_wrap && commit_ff);
	c_guard_drop: cover property (bit_acc && match && guard_ff != 7'h00);
endmodule
`default_nettype wire

// ---- rtl/led_rx_pkg.sv ----
// constants, types and helpers shared by the gradation receiver
package led_rx_pkg;

	// clock and link timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int CLK_PERIOD_NS = 40;
	localparam int BIT_NS_MIN    = 500;   // fastest rate, 2.0 MHz
	localparam int BIT_NS_MAX    = 2000;  // slowest rate, 0.5 MHz
	localparam int JIT_NS        = 54;    // jitter either side of an edge
	localparam int WIN_NS        = 135;   // least detection window
	localparam int TOL_CYC       = (JIT_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int WIN_CYC       = 2 * TOL_CYC + 1;
	localparam int WIN_MIN_CYC   = (WIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int PER_MIN_CYC   = BIT_NS_MIN / CLK_PERIOD_NS - TOL_CYC;
	localparam int PER_MAX_CYC   = (BIT_NS_MAX + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS + TOL_CYC;

	// timer widths and sized copies
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] TOL_C     = CNT_W'(TOL_CYC);
	localparam logic [CNT_W-1:0] PER_MIN_C = CNT_W'(PER_MIN_CYC);
	localparam logic [CNT_W-1:0] PER_MAX_C = CNT_W'(PER_MAX_CYC);
	localparam logic [CNT_W-1:0] CNT_ONE   = 7'h01;
	localparam logic [CNT_W-1:0] CNT_SAT   = 7'h7F;

	// line filter: changes shorter than this many cycles are dropped
	localparam int FILT_CYC = 2;
	localparam logic [1:0] FILT_LAST = 2'(FILT_CYC - 1);

	// pwm reference and frame spacing
	localparam int PWM_HZ  = 70_000;
	localparam int PWM_DIV = CLK_HZ / PWM_HZ;
	localparam int GAP_PWM = 127;
	localparam logic [6:0] GAP_C = 7'(GAP_PWM);

	// frame layout
	localparam int NUM_CH    = 24;
	localparam int VAL_W     = 7;
	localparam int ADDR_W    = 6;
	localparam int MODE_W    = 2;
	localparam int HDR_BITS  = ADDR_W + MODE_W;
	localparam logic [3:0] HDR_LAST  = 4'(HDR_BITS);
	localparam logic [2:0] VBIT_LAST = 3'(VAL_W - 1);
	localparam logic [4:0] CH_FULL   = 5'h18;
	localparam logic [4:0] CH_SIX    = 5'h06;
	localparam logic [4:0] CH_TWELVE = 5'h0C;

	typedef enum logic [MODE_W-1:0] {
		MODE_FULL     = 2'h0,
		MODE_SIX      = 2'h1,
		MODE_TWELVE   = 2'h2,
		MODE_FULL_ALT = 2'h3
	} mode_t;

	// three identity pins, each a 2-bit level code (ground, mid, supply)
	typedef struct packed {
		logic [1:0] identity_select_pin_c;
		logic [1:0] identity_select_pin_b;
		logic [1:0] identity_select_pin_a;
	} ident_pins_t;

	// one channel write toward the shadow bank
	typedef struct packed {
		logic             en;
		logic [4:0]       idx;
		logic [VAL_W-1:0] val;
	} chan_wr_t;

	// number of channel slots a mode accepts
	function automatic logic [4:0] mode_limit(input mode_t m);
		case (m)
			MODE_SIX:    mode_limit = CH_SIX;
			MODE_TWELVE: mode_limit = CH_TWELVE;
			default:     mode_limit = CH_FULL;
		endcase
	endfunction

endpackage

// ---- rtl/pwm_engine.sv ----
// free-running 7-bit pwm counter with per-channel comparators
`timescale 1ns/100ps
`default_nettype none
module pwm_engine
	import led_rx_pkg::*;
#(
	parameter int N_CH = NUM_CH,
	parameter int DIV  = PWM_DIV
) (
	input  wire logic                        clk,
	input  wire logic                        rst_n,
	input  wire logic                        ce,
	input  wire logic [N_CH-1:0][VAL_W-1:0]  duty,
	output logic      [N_CH-1:0]             pwm_out,
	output logic                             tick,
	output logic                             wrap
);
	localparam logic [8:0] DIV_LAST = 9'(DIV - 1);
	localparam logic [VAL_W-1:0] CNT_TOP = 7'h7F;

	logic [8:0]       pre_ff;
	logic [VAL_W-1:0] cnt_ff;
	logic [N_CH-1:0]  pwm_ff;

	// reference clock divider
	always_ff @(posedge clk) begin
		if (!rst_n)
			pre_ff <= 9'h000;
		else if (ce)
			pre_ff <= (pre_ff == DIV_LAST) ? 9'h000 : pre_ff + 9'h001;
	end

	assign tick = ce && (pre_ff == DIV_LAST);
	assign wrap = tick && (cnt_ff == CNT_TOP);

	// 7-bit duty counter
	always_ff @(posedge clk) begin
		if (!rst_n)
			cnt_ff <= 7'h00;
		else if (tick)
			cnt_ff <= cnt_ff + 7'h01;
	end

	// (R15) duty compare per channel
	genvar i;
	generate
		for (i = 0; i < N_CH; i++) begin : g_ch
			always_ff @(posedge clk) begin
				if (!rst_n)
					pwm_ff[i] <= 1'b0;
				else if (ce)
					pwm_ff[i] <= (duty[i] > cnt_ff);
			end
		end
	endgenerate

	assign pwm_out = pwm_ff;
endmodule
`default_nettype wire

// ---- dv/frame_host.sv ----
// host model that drives gradation frames onto the single data line
`timescale 1ns/100ps
`default_nettype none
module frame_host (
	input  wire logic clk,
	output logic      line
);
	int t_cyc;

	// push-pull line, idle high
	initial line = 1'b1;

	// one cell: value edge at T, mid-cell edge when level already matches
	task automatic put_bit(input logic b);
		if (line == b) begin
			repeat (t_cyc / 2) @(negedge clk);
			line = ~b;
			repeat (t_cyc - t_cyc / 2) @(negedge clk);
		end else begin
			repeat (t_cyc) @(negedge clk);
		end
		line = b;
	endtask

	// whole frame: start, address, mode, n values msb first
	task automatic send(input logic [5:0] a, input logic [1:0] m,
		input int n, input int t, input logic [23:0] pat);
		logic [31:0] ext;
		logic [6:0]  v;
		ext = {8'hFF, pat};
		t_cyc = t;
		@(negedge clk);
		line = 1'b0;
		repeat (t) @(negedge clk);
		line = 1'b1;
		for (int i = 5; i >= 0; i--) put_bit(a[i]);
		for (int i = 1; i >= 0; i--) put_bit(m[i]);
		for (int c = 0; c < n; c++) begin
			v = ext[c] ? 7'h7F : 7'h00;
			for (int i = 6; i >= 0; i--) put_bit(v[i]);
		end
		// leave line high, then idle over a bit before next start
		if (!line) begin
			repeat (t / 2) @(negedge clk);
			line = 1'b1;
		end
		repeat (t + 6) @(negedge clk);
	endtask
endmodule
`default_nettype wire

// ---- dv/tb_led_gradation_data_receiver.sv ----
// self-checking bench for the gradation frame receiver
`timescale 1ns/100ps
`default_nettype none
module tb_led_gradation_data_receiver
	import led_rx_pkg::*;
;
	localparam logic [5:0]  OWN_ID   = 6'h18;
	localparam ident_pins_t OWN_PINS = 6'h18;
	localparam int          SIM_DIV  = 4;  // short pwm period, brief run

	typedef struct {
		logic [5:0]  a;
		mode_t       m;
		int          n;
		int          t;
		logic [23:0] p;
		int          ok;
	} row_t;

	logic              clk   = 1'b0;
	logic              rst_n = 1'b0;
	logic              ce    = 1'b1;
	logic              line;
	logic              data_out;
	logic [NUM_CH-1:0] led_on;
	logic              frame_ok;
	logic              prev_in = 1'b1;
	int                n_ok = 0;
	int                n_mismatch = 0;
	int                checks = 0;

	// other ids first, then own empty frame, then own long frame
	row_t rows [4] = '{
		'{6'h05, MODE_FULL, 24, 13, 24'hFFFFFF, 0},
		'{6'h19, MODE_SIX, 6, 50, 24'hFFFFFF, 0},
		'{OWN_ID, MODE_FULL, 0, 20, 24'h000000, 0},
		'{OWN_ID, MODE_FULL, 26, 50, 24'hA5A5A5, 1}
	};

	always #20 clk = ~clk;

	frame_host host (
		.clk  (clk),
		.line (line)
	);

	led_gradation_data_receiver #(
		.REF_DIV (SIM_DIV)
	) dut_u (
		.clk        (clk),
		.rst_n      (rst_n),
		.ce         (ce),
		.data_in    (line),
		.ident_pins (OWN_PINS),
		.data_out   (data_out),
		.led_on     (led_on),
		.frame_ok   (frame_ok)
	);

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] s);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic results();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// wait for a committed pattern at a wrap, then see it stay
	task automatic wait_led(input logic [23:0] e);
		int i;
		i = 0;
		while (led_on !== e && i < 3 * 128 * SIM_DIV) begin
			@(negedge clk);
			i++;
		end
		chk("led_on", e, led_on);
		// one full pwm period later, same phase of the counter
		repeat (128 * SIM_DIV) @(negedge clk);
		chk("led_on held", e, led_on);
	endtask

	// line history and frame_ok pulse count
	always @(posedge clk) begin
		if (ce)
			prev_in <= line;
		if (frame_ok === 1'b1)
			n_ok <= n_ok + 1;
	end

	// buffered line copy, one cycle late
	always @(negedge clk)
		if (rst_n) chk("data_out", prev_in, data_out);

	// about 23k cycles of work expected, cut at 40k
	initial begin
		#1_600_000;
		n_mismatch++;
		results();
	end

	initial begin
		int base;
		repeat (5) @(negedge clk);
		chk("led_on", 0, led_on);
		chk("frame_ok", 0, frame_ok);
		chk("data_out", 1, data_out);
		rst_n = 1'b1;
		$display("reset test done");
		repeat (2) @(negedge clk);
		foreach (rows[i]) begin
			base = n_ok;
			host.send(rows[i].a, rows[i].m, rows[i].n, rows[i].t, rows[i].p);
			chk("frame_ok count", rows[i].ok, n_ok - base);
			$display("row %0d done", i);
		end
		wait_led(24'hA5A5A5);
		$display("first commit test done");
		repeat (130 * SIM_DIV) @(negedge clk);
		base = n_ok;
		host.send(OWN_ID, MODE_TWELVE, 14, 13, 24'hFFFFFF);
		chk("frame_ok count", 1, n_ok - base);
		// too soon after the last own frame: its values are dropped
		base = n_ok;
		host.send(OWN_ID, MODE_FULL_ALT, 1, 13, 24'h000000);
		chk("frame_ok count", 0, n_ok - base);
		wait_led(24'hA5AFFF);
		$display("twelve mode test done");
		// frozen while ce is low: a frame on the line is not taken
		repeat (130 * SIM_DIV) @(negedge clk);
		ce   = 1'b0;
		base = n_ok;
		host.send(OWN_ID, MODE_FULL, 1, 13, 24'h000000);
		chk("frame_ok count", 0, n_ok - base);
		ce = 1'b1;
		$display("clock enable test done");
		// six-channel mode at the slowest rate, surplus slots dropped
		repeat (2) @(negedge clk);
		base = n_ok;
		host.send(OWN_ID, MODE_SIX, 8, 50, 24'h000000);
		chk("frame_ok count", 1, n_ok - base);
		wait_led(24'hA5AFC0);
		$display("six mode test done");
		results();
	end
endmodule
`default_nettype wire
